//--- hw/tas_alarm_top.sv
// Status, mask and alarm output logic for three over-temperature alarms.
// Assumes the command port is fed by the device's serial interface logic.
// Notes on behaviour
// - Third-alarm status is read-only at 0x0A; bits 7..3 read zero.
// - Third alarm asserts while any unmasked third status bit is set.
// - Third alarm releases once all its unmasked status bits are clear.
// - Bit 2 sets at remote B second limit; clears below limit less hyst.
// - Bit 1 sets at remote A second limit; clears below limit less hyst.
// - Bit 0 sets at local limit, clears below limit minus hysteresis.
// - Model flag register at 0x38; bit 2 flags remote B mismatch.
// - Bit 1 flags remote A mismatch; bits 7..3 and 0 read zero.
// - First-alarm mask at 0x0C resets to 0x01; upper bits read zero.
// - A first-mask one blocks that channel from the first alarm.
// - Second-alarm mask at 0x0D resets to 0x00; one blocks the channel.
// - Third-alarm mask at 0x0E resets to 0x07; one blocks the channel.
// - First-alarm status uses first remote limits and the local limit.
`timescale 1ns/1ps
`default_nettype none

module tas_alarm_top (
    input wire logic clock,
    input wire logic reset_n,
    input wire tas_pkg::tas_cmd_t cmd,
    input wire tas_pkg::tas_reading_t reading,
    input wire tas_pkg::tas_thresh_t thresh,
    input wire logic [1:0] beta_comp_on,
    input wire logic [1:0] simple_model_seen,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic alarm_out_first_n,
    output logic alarm_out_second_n,
    output logic alarm_out_third_n
);

    logic [2:0] mask1_r;
    logic [2:0] mask2_r;
    logic [2:0] mask3_r;
    logic [1:0] mismatch_r;
    logic [7:0] rd_data_r;
    logic rd_valid_r;
    logic alarm1_n_r;
    logic alarm2_n_r;
    logic alarm3_n_r;

    wire logic [7:0] chan_reading [tas_pkg::NUM_CH];
    wire logic [tas_pkg::NUM_AL*tas_pkg::NUM_CH-1:0] status_flat;
    wire logic [2:0] status1;
    wire logic [2:0] status2;
    wire logic [2:0] status3;

    assign chan_reading[tas_pkg::CH_LOCAL] = reading.temp_local;
    assign chan_reading[tas_pkg::CH_REMOTE_A] = reading.temp_remote_a;
    assign chan_reading[tas_pkg::CH_REMOTE_B] = reading.temp_remote_b;

    // One comparator per alarm and channel; second and third share limits
    for (genvar a = 0; a < tas_pkg::NUM_AL; a++)
    begin : g_alarm
        for (genvar c = 0; c < tas_pkg::NUM_CH; c++)
        begin : g_chan
            wire logic [7:0] lim;
            assign lim = (c == tas_pkg::CH_LOCAL) ? thresh.limit_local :
                (a == tas_pkg::AL_FIRST) ?
                    ((c == tas_pkg::CH_REMOTE_A) ? thresh.limit_ra_first
                                                 : thresh.limit_rb_first) :
                    ((c == tas_pkg::CH_REMOTE_A) ? thresh.limit_ra_second
                                                 : thresh.limit_rb_second);
            tas_hyst_cmp u_cmp (
                .clock(clock),
                .reset_n(reset_n),
                .reading(chan_reading[c]),
                .limit(lim),
                .hyst(thresh.hyst),
                .flag_r(status_flat[a*tas_pkg::NUM_CH+c])
            );
        end
    end

    assign status1 = status_flat[2:0];
    assign status2 = status_flat[5:3];
    assign status3 = status_flat[8:6];

    // Register port decode
    wire logic wr_go;
    wire logic rd_go;
    wire logic wr_mask1;
    wire logic wr_mask2;
    wire logic wr_mask3;
    wire logic [2:0] rd_field;
    wire logic [2:0] model_field;
    wire logic [7:0] rd_data_nxt;

    assign wr_go = cmd.valid & cmd.write;
    assign rd_go = cmd.valid & ~cmd.write;
    assign wr_mask1 = wr_go & (cmd.code == tas_pkg::CMD_MASK1);
    assign wr_mask2 = wr_go & (cmd.code == tas_pkg::CMD_MASK2);
    assign wr_mask3 = wr_go & (cmd.code == tas_pkg::CMD_MASK3);
    // Writes to read-only or unknown codes are dropped silently
    assign model_field = {mismatch_r[tas_pkg::MM_B],
                          mismatch_r[tas_pkg::MM_A], 1'b0};
    assign rd_field =
        (cmd.code == tas_pkg::CMD_STATUS3) ? status3 :
        (cmd.code == tas_pkg::CMD_MASK1) ? mask1_r :
        (cmd.code == tas_pkg::CMD_MASK2) ? mask2_r :
        (cmd.code == tas_pkg::CMD_MASK3) ? mask3_r :
        (cmd.code == tas_pkg::CMD_MODEL) ? model_field :
        3'h0;
    assign rd_data_nxt = {tas_pkg::RSVD_ZERO, rd_field};

    // Masking: a one in a mask bit blocks that channel
    wire logic alarm1_n_nxt;
    wire logic alarm2_n_nxt;
    wire logic alarm3_n_nxt;

    assign alarm1_n_nxt = ~|(status1 & ~mask1_r);
    assign alarm2_n_nxt = ~|(status2 & ~mask2_r);
    assign alarm3_n_nxt = ~|(status3 & ~mask3_r);

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mask1_r <= tas_pkg::MASK1_RST;
            mask2_r <= tas_pkg::MASK2_RST;
            mask3_r <= tas_pkg::MASK3_RST;
        end
        else
        begin
            if (wr_mask1)
            begin
                mask1_r <= cmd.wdata[tas_pkg::FIELD_W-1:0];
            end
            if (wr_mask2)
            begin
                mask2_r <= cmd.wdata[tas_pkg::FIELD_W-1:0];
            end
            if (wr_mask3)
            begin
                mask3_r <= cmd.wdata[tas_pkg::FIELD_W-1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mismatch_r <= tas_pkg::MODEL_RST;
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            mismatch_r <= beta_comp_on & simple_model_seen;
            rd_data_r <= rd_go ? rd_data_nxt : rd_data_r;
            rd_valid_r <= rd_go;
        end
    end

    // Registered outputs give one cycle of lag, well inside the limit
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            alarm1_n_r <= 1'b1;
            alarm2_n_r <= 1'b1;
            alarm3_n_r <= 1'b1;
        end
        else
        begin
            alarm1_n_r <= alarm1_n_nxt;
            alarm2_n_r <= alarm2_n_nxt;
            alarm3_n_r <= alarm3_n_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign alarm_out_first_n = alarm1_n_r;
    assign alarm_out_second_n = alarm2_n_r;
    assign alarm_out_third_n = alarm3_n_r;

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    wire logic [8:0] loc_floor;
    wire logic loc_below;
    assign loc_floor = {1'b0, thresh.limit_local} - {1'b0, thresh.hyst};
    assign loc_below = ~loc_floor[8] & (reading.temp_local < loc_floor[7:0]);

    status3_read_a: assert property (
        rd_go && cmd.code == tas_pkg::CMD_STATUS3 |=>
            rd_valid && rd_data == {5'h00, $past(status3)})
        else $error("third status read wrong");

    alarm3_assert_a: assert property (
        |(status3 & ~mask3_r) |=> !alarm_out_third_n)
        else $error("third alarm not asserted");

    alarm3_release_a: assert property (
        !alarm_out_third_n |-> $past(|(status3 & ~mask3_r)))
        else $error("third alarm active without cause");

    rb_set_a: assert property (
        reading.temp_remote_b >= thresh.limit_rb_second |=>
            status3[tas_pkg::CH_REMOTE_B] && status2[tas_pkg::CH_REMOTE_B])
        else $error("remote b status not set");

    ra_set_a: assert property (
        reading.temp_remote_a >= thresh.limit_ra_second |=>
            status3[tas_pkg::CH_REMOTE_A] && status2[tas_pkg::CH_REMOTE_A])
        else $error("remote a status not set");

    local_hold_clear_a: assert property (
        (loc_below |=> !status3[tas_pkg::CH_LOCAL]) and
        (status3[tas_pkg::CH_LOCAL] && !loc_below |=>
            status3[tas_pkg::CH_LOCAL]))
        else $error("local hysteresis wrong");

    model_read_a: assert property (
        rd_go && cmd.code == tas_pkg::CMD_MODEL |=>
            rd_data[7:3] == 5'h00 && rd_data[0] == 1'b0 &&
            rd_data[2] == $past(mismatch_r[tas_pkg::MM_B]))
        else $error("model flag b wrong");

    model_a_flag_a: assert property (
        beta_comp_on[tas_pkg::MM_A] && simple_model_seen[tas_pkg::MM_A]
            ##1 (rd_go && cmd.code == tas_pkg::CMD_MODEL) |=> rd_data[1])
        else $error("model flag a missing");

    mask1_write_a: assert property (
        wr_mask1 |=> mask1_r == $past(cmd.wdata[2:0]))
        else $error("first mask write lost");

    alarm1_gate_a: assert property (
        alarm_out_first_n == !$past(|(status1 & ~mask1_r)))
        else $error("first alarm gating wrong");

    alarm2_gate_a: assert property (
        alarm_out_second_n == !$past(|(status2 & ~mask2_r)))
        else $error("second alarm gating wrong");

    mask3_block_a: assert property (
        mask3_r == 3'h7 && !wr_mask3 |=> alarm_out_third_n)
        else $error("third mask fails to block");

    first_set_a: assert property (
        reading.temp_remote_a >= thresh.limit_ra_first |=>
            status1[tas_pkg::CH_REMOTE_A])
        else $error("first status not set");

    alarm3_follow_a: assert property (
        $rose(|(status3 & ~mask3_r)) |=> $fell(alarm_out_third_n))
        else $error("third alarm lagging");

    // Writes land at the next edge; bits above the field are dropped
    mask2_write_a: assert property (
        wr_mask2 |=> mask2_r == $past(cmd.wdata[2:0]))
        else $error("second mask write lost");

    mask3_write_a: assert property (
        wr_mask3 |=> mask3_r == $past(cmd.wdata[2:0]))
        else $error("third mask write lost");

    mask1_read_a: assert property (
        rd_go && cmd.code == tas_pkg::CMD_MASK1 |=>
            rd_valid && rd_data == {5'h00, $past(mask1_r)})
        else $error("first mask read wrong");

    mask3_read_a: assert property (
        rd_go && cmd.code == tas_pkg::CMD_MASK3 |=>
            rd_valid && rd_data == {5'h00, $past(mask3_r)})
        else $error("third mask read wrong");

    // The first edge after release still shows untouched reset values; masks keep them until written
    mask_reset_a: assert property (
        $rose(reset_n) |->
            mask1_r == tas_pkg::MASK1_RST && mask2_r == tas_pkg::MASK2_RST &&
            mask3_r == tas_pkg::MASK3_RST)
        else $error("mask reset value wrong");

    alarm3_drop_a: assert property (
        $rose(alarm_out_third_n) |-> !$past(|(status3 & ~mask3_r)))
        else $error("third alarm released with cause");

    first_b_set_a: assert property (
        reading.temp_remote_b >= thresh.limit_rb_first |=>
            status1[tas_pkg::CH_REMOTE_B])
        else $error("first remote b status not set");

    first_local_set_a: assert property (
        reading.temp_local >= thresh.limit_local |=>
            status1[tas_pkg::CH_LOCAL] && status3[tas_pkg::CH_LOCAL])
        else $error("local status not set");

    cov_alarm1_c: cover property ($fell(alarm_out_first_n));
    cov_alarm3_rel_c: cover property ($rose(alarm_out_third_n));
    cov_model_c: cover property (rd_valid && rd_data[2]);
    cov_mask_wr_c: cover property (wr_mask2 ##1 !alarm_out_second_n);
    cov_hold_c: cover property (status3[tas_pkg::CH_LOCAL] &&
        !loc_below && reading.temp_local < thresh.limit_local);

endmodule

`default_nettype wire

//--- hw/tas_pkg.sv
// Shared constants and carrier types for the thermal alarm status/mask block.
// Assumes one clock domain; readings and limits come from on-chip logic.
package tas_pkg;

    // Command codes of the registers this block answers
    localparam logic [7:0] CMD_STATUS3 = 8'h0a;
    localparam logic [7:0] CMD_MASK1 = 8'h0c;
    localparam logic [7:0] CMD_MASK2 = 8'h0d;
    localparam logic [7:0] CMD_MASK3 = 8'h0e;
    localparam logic [7:0] CMD_MODEL = 8'h38;

    // Mask and status registers hold three live bits in the low end; model bit 0 reads zero
    localparam int FIELD_W = 3;
    localparam logic [4:0] RSVD_ZERO = 5'h00;

    // Reset values of the mask, status and model flag registers
    localparam logic [2:0] MASK1_RST = 3'h1;
    localparam logic [2:0] MASK2_RST = 3'h0;
    localparam logic [2:0] MASK3_RST = 3'h7;
    localparam logic [2:0] STATUS_RST = 3'h0;
    localparam logic [1:0] MODEL_RST = 2'h0;

    // Bit position of each channel in status and mask fields
    localparam int CH_LOCAL = 0;
    localparam int CH_REMOTE_A = 1;
    localparam int CH_REMOTE_B = 2;
    localparam int NUM_CH = 3;

    // Alarm output indices
    localparam int AL_FIRST = 0;
    localparam int AL_SECOND = 1;
    localparam int AL_THIRD = 2;
    localparam int NUM_AL = 3;

    // Index into the two-bit mismatch inputs
    localparam int MM_A = 0;
    localparam int MM_B = 1;

    // One register access per cycle on the command port
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [7:0] wdata;
    } tas_cmd_t;

    typedef struct packed {
        logic [7:0] temp_local;
        logic [7:0] temp_remote_a;
        logic [7:0] temp_remote_b;
    } tas_reading_t;

    typedef struct packed {
        logic [7:0] limit_local;
        logic [7:0] limit_ra_first;
        logic [7:0] limit_rb_first;
        logic [7:0] limit_ra_second;
        logic [7:0] limit_rb_second;
        logic [7:0] hyst;
    } tas_thresh_t;

endpackage

//--- hw/tas_hyst_cmp.sv
// One over-temperature status bit with hysteresis on falling temperature.
// Assumes reading, limit and hysteresis are synchronous to clock.
`timescale 1ns/1ps
`default_nettype none

module tas_hyst_cmp (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] reading,
    input wire logic [7:0] limit,
    input wire logic [7:0] hyst,
    output logic flag_r
);

    logic flag_nxt;
    wire logic at_or_above;
    wire logic [8:0] floor_ext;
    wire logic below_floor;

    assign at_or_above = reading >= limit;
    // A hysteresis larger than the limit leaves no floor, so the bit holds
    assign floor_ext = {1'b0, limit} - {1'b0, hyst};
    assign below_floor = ~floor_ext[8] & (reading < floor_ext[7:0]);
    assign flag_nxt = at_or_above | (flag_r & ~below_floor);

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flag_r <= 1'b0;
        end
        else
        begin
            flag_r <= flag_nxt;
        end
    end

endmodule

`default_nettype wire

//--- sim/tas_host_model.sv
// Host-side stand-in for the serial master: one register access at a time.
// Assumes the block takes cmd at a rising edge while valid is high.
`timescale 1ns/1ps
`default_nettype none

module tas_host_model (
    input wire logic clock,
    output var tas_pkg::tas_cmd_t cmd
);
    initial cmd = '0;

    task automatic access(input logic wr, input logic [7:0] code,
        input logic [7:0] data);
    begin
        @(posedge clock);
        cmd <= {1'b1, wr, code, data};
        @(posedge clock);
        // Released lines must not keep their last value
        cmd <= {1'b0, ~wr, ~code, ~data};
    end
    endtask
endmodule

`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the thermal alarm status and mask block.
// Assumes the host model drives the register port; readings are random.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    wire tas_pkg::tas_cmd_t cmd;
    tas_pkg::tas_reading_t reading = '0;
    tas_pkg::tas_thresh_t thresh = {8'h50, 8'h60, 8'h70, 8'h58, 8'h68, 8'h0a};
    logic [1:0] beta_comp_on = 2'h0;
    logic [1:0] simple_model_seen = 2'h0;
    logic [7:0] rd_data;
    logic rd_valid;
    logic al1_n;
    logic al2_n;
    logic al3_n;
    logic [7:0] exp_q[$];
    logic [2:0] st1 = 3'h0;
    logic [2:0] st23 = 3'h0;
    logic [2:0] m1 = 3'h1;
    logic [2:0] m2 = 3'h0;
    logic [2:0] m3 = 3'h7;
    logic [31:0] v;
    int n_mismatch = 0;
    int n_checks = 0;
    int seed = 32'h6d6b;

    tas_alarm_top DUT (.clock(clock), .reset_n(reset_n), .cmd(cmd),
        .reading(reading), .thresh(thresh), .beta_comp_on(beta_comp_on),
        .simple_model_seen(simple_model_seen), .rd_data(rd_data),
        .rd_valid(rd_valid), .alarm_out_first_n(al1_n),
        .alarm_out_second_n(al2_n), .alarm_out_third_n(al3_n));

    tas_host_model host (.clock(clock), .cmd(cmd));

    always #2 clock = ~clock;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_al(input logic [2:0] got, input logic [2:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: alarms %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic rd(input logic [7:0] code, input logic [7:0] exp);
        exp_q.push_back(exp);
        host.access(1'b0, code, 8'h00);
    endtask

    // Set hits at the limit; clear only below limit minus hysteresis
    function automatic logic upd(input logic s, input logic [7:0] r,
        input logic [7:0] lim, input logic [7:0] h);
        if (r >= lim)
            return 1'b1;
        if (lim >= h && r < lim - h)
            return 1'b0;
        return s;
    endfunction

    // New random readings and diode flags, held until everything settles
    task automatic step();
        logic [7:0] rl;
        logic [7:0] ra;
        logic [7:0] rb;
        logic [2:0] exp_al;
        v = $random(seed);
        rl = (v[7:0] & 8'h3f) | 8'h40;
        ra = (v[15:8] & 8'h3f) | 8'h40;
        rb = (v[23:16] & 8'h3f) | 8'h40;
        @(posedge clock);
        reading <= {rl, ra, rb};
        beta_comp_on <= v[25:24];
        simple_model_seen <= v[27:26];
        repeat (3) @(posedge clock);
        st1 = {upd(st1[2], rb, thresh.limit_rb_first, thresh.hyst),
            upd(st1[1], ra, thresh.limit_ra_first, thresh.hyst),
            upd(st1[0], rl, thresh.limit_local, thresh.hyst)};
        st23 = {upd(st23[2], rb, thresh.limit_rb_second, thresh.hyst),
            upd(st23[1], ra, thresh.limit_ra_second, thresh.hyst),
            upd(st23[0], rl, thresh.limit_local, thresh.hyst)};
        @(negedge clock);
        exp_al = ~{|(st23 & ~m3), |(st23 & ~m2), |(st1 & ~m1)};
        cmp_al({al3_n, al2_n, al1_n}, exp_al);
        rd(tas_pkg::CMD_STATUS3, {5'h00, st23});
        rd(tas_pkg::CMD_MODEL, {5'h00, v[25:24] & v[27:26], 1'b0});
    endtask

    // Answers are matched to the oldest outstanding read
    always @(posedge clock)
        if (rd_valid === 1'b1)
        begin
            if (exp_q.size() > 0)
                cmp_rd(rd_data, exp_q.pop_front());
            else
            begin
                n_mismatch++;
                $display("mismatch at %0t: read %h expected none", $time,
                    rd_data);
            end
        end

    initial
    begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        @(negedge clock);
        cmp_al({al3_n, al2_n, al1_n}, 3'h7);
        rd(tas_pkg::CMD_MASK1, 8'h01);
        rd(tas_pkg::CMD_MASK2, 8'h00);
        rd(tas_pkg::CMD_MASK3, 8'h07);
        host.access(1'b1, tas_pkg::CMD_STATUS3, 8'hff);
        rd(tas_pkg::CMD_STATUS3, 8'h00);
        host.access(1'b1, tas_pkg::CMD_MODEL, 8'hff);
        rd(tas_pkg::CMD_MODEL, 8'h00);
        rd(8'h09, 8'h00);
        for (int i = 0; i < 60; i++)
        begin
            // Late iterations use a hysteresis above some limits
            if (i == 45)
                thresh.hyst <= 8'h5c;
            v = $random(seed);
            host.access(1'b1, 8'h0c + 8'(i % 3), v[7:0]);
            rd(8'h0c + 8'(i % 3), {5'h00, v[2:0]});
            if (i % 3 == 0)
                m1 = v[2:0];
            else if (i % 3 == 1)
                m2 = v[2:0];
            else
                m3 = v[2:0];
            step();
        end
        for (int k = 0; k < 20 && exp_q.size() > 0; k++)
            @(posedge clock);
        if (exp_q.size() > 0)
            n_mismatch++;
        finish_test();
    end

    initial
    begin
        #200000;
        n_mismatch++;
        finish_test();
    end
endmodule

`default_nettype wire
